/* rtl/clam_map.svh */
// Register offsets, field positions, reset values and timing constants
`ifndef CLAM_MAP_SVH
`define CLAM_MAP_SVH
`define CLAM_ADDR_W 8
`define CLAM_OFS_FLAGS 8'h00
`define CLAM_OFS_INRUSH 8'h04
`define CLAM_OFS_CTRL_CAP 8'h08
`define CLAM_OFS_MAIN_CAP 8'h0C
`define CLAM_OFS_MEASURE 8'h10
`define CLAM_OFS_SEL_A 8'h14
`define CLAM_OFS_SEL_B 8'h18
`define CLAM_OFS_SEL_C 8'h1C
`define CLAM_OFS_INRUSH_CNT 8'h20
`define CLAM_BIT_CTRL_CAP 0
`define CLAM_BIT_MAIN_CAP 1
`define CLAM_BIT_FAN 2
`define CLAM_BIT_INRUSH 3
`define CLAM_LIFE_FULL 7'h64
`define CLAM_INRUSH_ALARM_PCT 7'h0A
`define CLAM_CTRL_ALARM_PCT 7'h0A
`define CLAM_MAIN_ALARM_PCT 7'h55
`define CLAM_FAN_ALARM_PCT 7'h28
`define CLAM_INRUSH_PER_PCT 14'h270F
`define CLAM_CODE_IDLE 4'h0
`define CLAM_CODE_ARMED 4'h1
`define CLAM_CODE_RUN 4'h2
`define CLAM_CODE_DONE 4'h3
`define CLAM_CODE_FORCED 4'h8
`define CLAM_CODE_ERROR 4'h9
`define CLAM_SEL_SOURCE 8'h5A
`define CLAM_SEL_SINK 8'hBE
`define CLAM_SEL_RESET 8'h00
`define CLAM_CLK_PERIOD_NS 5
`define CLAM_DC_INJECT_NS 1000000000
`define CLAM_DC_INJECT_CYCLES (`CLAM_DC_INJECT_NS / `CLAM_CLK_PERIOD_NS)
`define CLAM_CAP_UNITS_PER_PCT 1000000
`endif

/* rtl/clam_pkg.sv */
// Types shared by the life alarm monitor
package clam_pkg;
   typedef enum logic [2:0] {
      MEAS_IDLE, MEAS_ARMED, MEAS_RUN, MEAS_DONE, MEAS_FORCED, MEAS_ERROR
   } clam_meas_e;
   typedef struct packed {
      logic [6:0] inrush;
      logic [6:0] ctrl_cap;
      logic [6:0] main_cap;
   } clam_life_s;
   typedef struct packed {
      logic power_off;
      logic power_restored;
      logic start_cmd;
      logic output_shutoff_input;
      logic motor_present;
      logic motor_coasting;
   } clam_meas_cond_s;
endpackage

/* rtl/clam_monitor.sv */
// Component life alarm monitor with APB register access
//
// Contract
// - Four-bit flags: bit0 control cap, bit1 main cap, bit2 fan, bit3 inrush.
// - Life alarm asserts when any monitored component reaches its threshold; control cap must fall below it.
// - Terminal carries alarm for select code 90, inverted for code 190.
// - Inrush life drops one percent per 10000 activations, from 100 percent.
// - Inrush life at 10 percent sets bit 3 and the alarm.
// - Power-on, undervoltage and inverter reset each count one activation; events in the same cycle count as one.
// - While running, control cap life falls with energizing time and heat.
// - Control cap life below 10 percent sets bit 0 and the alarm.
// - Main cap life updates after each completed measurement.
// - Measured main cap life at or below 85 sets bit 1 and alarm.
// - Measure codes: 0 idle, 1 armed, 2 running, 3 done, 8 forced, 9 error.
// - Armed measurement starts at power-off and drives DC for one second.
// - Restore, start, shutoff, missing or coasting motor end in 8, 9 or 1.
// - Fan speed at or below 40 percent sets bit 2 and the alarm.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "clam_map.svh"
module clam_monitor #(
   parameter int unsigned DC_INJECT_CYCLES = `CLAM_DC_INJECT_CYCLES,
   parameter int unsigned CAP_UNITS_PER_PCT = `CLAM_CAP_UNITS_PER_PCT
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`CLAM_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Wear events and sensors
   input wire logic undervoltage_pulse,
   input wire logic inverter_reset_pulse,
   input wire logic running,
   input wire logic energize_tick,
   input wire logic [1:0] heatsink_level,
   input wire logic [6:0] fan_speed_pct,
   // Main capacitor measurement
   input wire clam_pkg::clam_meas_cond_s meas_cond,
   input wire logic [6:0] measured_cap_pct,
   output logic dc_inject_out,
   // Alarm outputs
   output logic life_alarm_out,
   output logic [2:0] terminal_out
);
   ////////////////////////////////////////////////////////////////////////
   logic [3:0] life_alarm_flags_reg;
   logic [6:0] inrush_life_reg, ctrl_life_reg, main_life_reg;
   clam_pkg::clam_life_s life_reg;
   clam_pkg::clam_meas_e meas_reg;
   logic main_measured_reg;
   logic por_pending_reg;
   logic [13:0] inrush_sub_reg;
   logic [19:0] inrush_count_reg;
   logic [31:0] cap_acc_reg;
   logic [31:0] dc_cnt_reg;
   logic [7:0] sel_reg [3];
   logic wr_en;
   logic addr_ok;
   logic activation;

   function automatic logic [3:0] meas_code(input clam_pkg::clam_meas_e s);
      unique case (s)
         clam_pkg::MEAS_IDLE: meas_code = `CLAM_CODE_IDLE;
         clam_pkg::MEAS_ARMED: meas_code = `CLAM_CODE_ARMED;
         clam_pkg::MEAS_RUN: meas_code = `CLAM_CODE_RUN;
         clam_pkg::MEAS_DONE: meas_code = `CLAM_CODE_DONE;
         clam_pkg::MEAS_FORCED: meas_code = `CLAM_CODE_FORCED;
         clam_pkg::MEAS_ERROR: meas_code = `CLAM_CODE_ERROR;
      endcase
   endfunction

   // Terminal drive for one function selection code
   function automatic logic term_drive(input logic [7:0] sel,
                                       input logic alarm);
      if (sel == `CLAM_SEL_SOURCE) begin
         term_drive = alarm;
      end else if (sel == `CLAM_SEL_SINK) begin
         term_drive = ~alarm;
      end else begin
         term_drive = 1'b0;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign life_reg = {inrush_life_reg, ctrl_life_reg, main_life_reg};
   always_comb begin
      unique case (paddr)
         `CLAM_OFS_FLAGS, `CLAM_OFS_INRUSH, `CLAM_OFS_CTRL_CAP,
         `CLAM_OFS_MAIN_CAP, `CLAM_OFS_MEASURE, `CLAM_OFS_SEL_A,
         `CLAM_OFS_SEL_B, `CLAM_OFS_SEL_C,
         `CLAM_OFS_INRUSH_CNT: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~addr_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         unique case (paddr)
            `CLAM_OFS_FLAGS: prdata <= {28'h0, life_alarm_flags_reg};
            `CLAM_OFS_INRUSH: prdata <= {25'h0, life_reg.inrush};
            `CLAM_OFS_CTRL_CAP: prdata <= {25'h0, life_reg.ctrl_cap};
            `CLAM_OFS_MAIN_CAP: prdata <= {25'h0, life_reg.main_cap};
            `CLAM_OFS_MEASURE: prdata <= {28'h0, meas_code(meas_reg)};
            `CLAM_OFS_SEL_A: prdata <= {24'h0, sel_reg[0]};
            `CLAM_OFS_SEL_B: prdata <= {24'h0, sel_reg[1]};
            `CLAM_OFS_SEL_C: prdata <= {24'h0, sel_reg[2]};
            `CLAM_OFS_INRUSH_CNT: prdata <= {12'h0, inrush_count_reg};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output terminal function selection
   for (genvar i = 0; i < 3; i++) begin : g_term
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sel_reg[i] <= `CLAM_SEL_RESET;
         end else if (wr_en && paddr == (`CLAM_OFS_SEL_A + 8'(4 * i))) begin
            sel_reg[i] <= pwdata[7:0];
         end
      end
      assign terminal_out[i] = term_drive(sel_reg[i], life_alarm_out);
   end

   ////////////////////////////////////////////////////////////////////////
   // Inrush limiter wear; power-on counts once after reset release
   assign activation = por_pending_reg | undervoltage_pulse
                       | inverter_reset_pulse;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_pending_reg <= 1'b1;
      end else begin
         por_pending_reg <= 1'b0;
      end
   end
   // Count and life survive only to the next reset; a real part keeps
   // them in nonvolatile storage outside this block.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inrush_count_reg <= 20'h00000;
         inrush_sub_reg <= 14'h0000;
         inrush_life_reg <= `CLAM_LIFE_FULL;
      end else if (activation) begin
         if (inrush_count_reg != 20'hFFFFF) begin
            inrush_count_reg <= inrush_count_reg + 20'h00001;
         end
         if (inrush_sub_reg == `CLAM_INRUSH_PER_PCT) begin
            inrush_sub_reg <= 14'h0000;
            if (inrush_life_reg != 7'h00) begin
               inrush_life_reg <= inrush_life_reg - 7'h01;
            end
         end else begin
            inrush_sub_reg <= inrush_sub_reg + 14'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control capacitor ageing: hotter heatsink weighs each tick more
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_acc_reg <= 32'h0000_0000;
         ctrl_life_reg <= `CLAM_LIFE_FULL;
      end else if (running && energize_tick) begin
         if (cap_acc_reg + 32'(heatsink_level) + 32'h1
             >= 32'(CAP_UNITS_PER_PCT)) begin
            cap_acc_reg <= 32'h0000_0000;
            if (ctrl_life_reg != 7'h00) begin
               ctrl_life_reg <= ctrl_life_reg - 7'h01;
            end
         end else begin
            cap_acc_reg <= cap_acc_reg + 32'(heatsink_level) + 32'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main capacitor measurement sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meas_reg <= clam_pkg::MEAS_IDLE;
         dc_cnt_reg <= 32'h0000_0000;
      end else begin
         unique case (meas_reg)
            clam_pkg::MEAS_ARMED: begin
               if (wr_en && paddr == `CLAM_OFS_MEASURE
                   && pwdata[3:0] == `CLAM_CODE_IDLE) begin
                  meas_reg <= clam_pkg::MEAS_IDLE;
               end else if (meas_cond.power_off) begin
                  // Shutoff keeps the arm pending
                  if (!meas_cond.motor_present || meas_cond.motor_coasting) begin
                     meas_reg <= clam_pkg::MEAS_ERROR;
                  end else if (!meas_cond.output_shutoff_input) begin
                     meas_reg <= clam_pkg::MEAS_RUN;
                     dc_cnt_reg <= 32'h0000_0000;
                  end
               end
            end
            clam_pkg::MEAS_RUN: begin
               if (meas_cond.power_restored || meas_cond.start_cmd
                   || meas_cond.output_shutoff_input) begin
                  meas_reg <= clam_pkg::MEAS_FORCED;
               end else if (!meas_cond.motor_present
                            || meas_cond.motor_coasting) begin
                  meas_reg <= clam_pkg::MEAS_ERROR;
               end else if (dc_cnt_reg == 32'(DC_INJECT_CYCLES - 1)) begin
                  meas_reg <= clam_pkg::MEAS_DONE;
               end else begin
                  dc_cnt_reg <= dc_cnt_reg + 32'h1;
               end
            end
            default: begin
               // Code 2 cannot be set; only 0 and 1 are accepted
               if (wr_en && paddr == `CLAM_OFS_MEASURE) begin
                  if (pwdata[3:0] == `CLAM_CODE_ARMED) begin
                     meas_reg <= clam_pkg::MEAS_ARMED;
                  end else if (pwdata[3:0] == `CLAM_CODE_IDLE) begin
                     meas_reg <= clam_pkg::MEAS_IDLE;
                  end
               end
            end
         endcase
      end
   end
   assign dc_inject_out = (meas_reg == clam_pkg::MEAS_RUN);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_life_reg <= `CLAM_LIFE_FULL;
         main_measured_reg <= 1'b0;
      end else if (meas_reg == clam_pkg::MEAS_RUN
                   && !meas_cond.power_restored && !meas_cond.start_cmd
                   && !meas_cond.output_shutoff_input
                   && meas_cond.motor_present && !meas_cond.motor_coasting
                   && dc_cnt_reg == 32'(DC_INJECT_CYCLES - 1)) begin
         main_life_reg <= measured_cap_pct;
         main_measured_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status word and alarm; main cap bit needs a completed measurement
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         life_alarm_flags_reg <= 4'h0;
      end else begin
         life_alarm_flags_reg[`CLAM_BIT_CTRL_CAP] <=
            life_reg.ctrl_cap < `CLAM_CTRL_ALARM_PCT;
         life_alarm_flags_reg[`CLAM_BIT_MAIN_CAP] <= main_measured_reg
            && life_reg.main_cap <= `CLAM_MAIN_ALARM_PCT;
         life_alarm_flags_reg[`CLAM_BIT_FAN] <=
            fan_speed_pct <= `CLAM_FAN_ALARM_PCT;
         life_alarm_flags_reg[`CLAM_BIT_INRUSH] <=
            life_reg.inrush <= `CLAM_INRUSH_ALARM_PCT;
      end
   end
   assign life_alarm_out = |life_alarm_flags_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   inrush_flag_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      life_reg.inrush <= `CLAM_INRUSH_ALARM_PCT
      |=> life_alarm_flags_reg[`CLAM_BIT_INRUSH])
      else $error("inrush flag not set at low life");
   inrush_step_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      $changed(life_reg.inrush) |-> $past(inrush_sub_reg) ==
      `CLAM_INRUSH_PER_PCT && $past(activation))
      else $error("inrush life stepped at wrong count");
   activation_count_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (activation && inrush_count_reg != 20'hFFFFF)
      |=> inrush_count_reg == $past(inrush_count_reg) + 20'h00001)
      else $error("activation not counted");
   ctrl_flag_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 life_alarm_flags_reg[`CLAM_BIT_CTRL_CAP] ==
      ($past(life_reg.ctrl_cap) < `CLAM_CTRL_ALARM_PCT))
      else $error("control cap flag wrong");
   ctrl_idle_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !running |=> $stable(life_reg.ctrl_cap))
      else $error("control cap aged while stopped");
   main_flag_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (main_measured_reg && life_reg.main_cap <= `CLAM_MAIN_ALARM_PCT)
      |=> life_alarm_out)
      else $error("main cap alarm missing");
   fan_flag_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      fan_speed_pct <= `CLAM_FAN_ALARM_PCT |=>
      life_alarm_flags_reg[`CLAM_BIT_FAN] && life_alarm_out)
      else $error("fan flag or alarm missing");
   alarm_or_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      life_alarm_out == (life_alarm_flags_reg != 4'h0))
      else $error("alarm not OR of flags");
   term_route_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      sel_reg[1] == `CLAM_SEL_SINK |-> terminal_out[1] == !life_alarm_out)
      else $error("sink terminal not inverted");
   start_forced_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (meas_reg == clam_pkg::MEAS_RUN && meas_cond.start_cmd)
      |=> meas_reg == clam_pkg::MEAS_FORCED && !dc_inject_out)
      else $error("start during measurement not forced");
   arm_start_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (meas_reg == clam_pkg::MEAS_ARMED && meas_cond.power_off
       && meas_cond.motor_present && !meas_cond.motor_coasting
       && !meas_cond.output_shutoff_input && !wr_en)
      |=> dc_inject_out && dc_cnt_reg == 32'h0)
      else $error("measurement did not start at power-off");
   done_cover_c: cover property (
      @(posedge pclk) disable iff (!presetn)
      meas_reg == clam_pkg::MEAS_RUN ##1 meas_reg == clam_pkg::MEAS_DONE);
   forced_cover_c: cover property (
      @(posedge pclk) disable iff (!presetn)
      meas_reg == clam_pkg::MEAS_FORCED);
   alarm_cover_c: cover property (
      @(posedge pclk) disable iff (!presetn) $rose(life_alarm_out));
endmodule
`default_nettype wire

/* rtl/clam_dummy_unused.sv */
// Holds no logic; the whole monitor lives in clam_monitor
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* bench/clam_controller_model.sv */
// Model of the remote controller watching one alarm output terminal
`timescale 1ns/10ps
`default_nettype none
module clam_controller_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Watched terminal and its wiring sense
   input wire logic terminal,
   input wire logic sink_logic,
   // Alarm as the controller decodes it
   output logic alarm_seen
);
   ////////////////////////////////////////////////////////////////////////////
   // A sink terminal pulls low on alarm, so the sense is flipped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_seen <= 1'b0;
      end else begin
         alarm_seen <= sink_logic ? ~terminal : terminal;
      end
   end
endmodule
`default_nettype wire

/* bench/component_life_alarm_monitor_bench.sv */
// Self-checking testbench for the component life alarm monitor
`timescale 1ns/10ps
`default_nettype none
`include "clam_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("Error %0t: got %0h want %0h", $time, g, e); end end
module component_life_alarm_monitor_bench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, err, uv = 1'b0, irst = 1'b0;
   logic running = 1'b0, tick = 1'b0, dc, alarm, seen;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0] heat = 2'h0;
   logic [6:0] fan = 7'h64, mcap = 7'h64;
   logic [2:0] term;
   // Only motor_present is high at start
   clam_pkg::clam_meas_cond_s cond = clam_pkg::clam_meas_cond_s'(6'h02);
   int failures = 0, n_tests = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Short counts keep the run small
   clam_monitor #(.DC_INJECT_CYCLES(8), .CAP_UNITS_PER_PCT(4)) clam_monitor_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .undervoltage_pulse(uv),
      .inverter_reset_pulse(irst), .running(running), .energize_tick(tick),
      .heatsink_level(heat), .fan_speed_pct(fan), .meas_cond(cond),
      .measured_cap_pct(mcap), .dc_inject_out(dc), .life_alarm_out(alarm),
      .terminal_out(term));
   clam_controller_model clam_controller_model_i (.pclk(pclk),
      .presetn(presetn), .terminal(term[1]), .sink_logic(1'b1),
      .alarm_seen(seen));
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One APB transfer; the wait for pready is bounded
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      i = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         failures++;
         $display("Error %0t: no pready", $time);
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   task automatic poff();
      cond.power_off <= 1'b1;
      step(1);
      cond.power_off <= 1'b0;
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         tick <= 1'b1;
         step(1);
         tick <= 1'b0;
         step(1);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      `CHK(alarm, 1'b0)
      rchk(`CLAM_OFS_FLAGS, 32'h0);
      rchk(`CLAM_OFS_INRUSH, 32'h64);
      rchk(`CLAM_OFS_CTRL_CAP, 32'h64);
      rchk(`CLAM_OFS_MAIN_CAP, 32'h64);
      rchk(`CLAM_OFS_MEASURE, 32'h0);
      rchk(`CLAM_OFS_INRUSH_CNT, 32'h1);
      // Unmapped place must be refused
      apb(1'b0, 8'h3C, 32'h0);
      `CHK(err, 1'b1)
   endtask
   task automatic t_inrush();
      uv <= 1'b1;
      step(1);
      uv <= 1'b0;
      irst <= 1'b1;
      step(1);
      irst <= 1'b0;
      rchk(`CLAM_OFS_INRUSH_CNT, 32'h3);
      apb(1'b1, `CLAM_OFS_INRUSH, 32'h0);
      rchk(`CLAM_OFS_INRUSH, 32'h64);
      // Three activations so far; the 10000th takes one percent off
      uv <= 1'b1;
      step(9996);
      uv <= 1'b0;
      rchk(`CLAM_OFS_INRUSH, 32'h64);
      uv <= 1'b1;
      step(1);
      uv <= 1'b0;
      rchk(`CLAM_OFS_INRUSH, 32'h63);
      rchk(`CLAM_OFS_INRUSH_CNT, 32'h2710);
   endtask
   task automatic t_fan();
      apb(1'b1, `CLAM_OFS_SEL_A, 32'h5A);
      apb(1'b1, `CLAM_OFS_SEL_B, 32'hBE);
      rchk(`CLAM_OFS_SEL_B, 32'hBE);
      fan <= 7'h29;
      step(3);
      rchk(`CLAM_OFS_FLAGS, 32'h0);
      `CHK(seen, 1'b0)
      fan <= 7'h28;
      step(3);
      rchk(`CLAM_OFS_FLAGS, 32'h4);
      `CHK(alarm, 1'b1)
      `CHK(term, 3'h1)
      `CHK(seen, 1'b1)
      fan <= 7'h29;
      step(3);
      `CHK(alarm, 1'b0)
      `CHK(term, 3'h2)
   endtask
   task automatic t_ctrl();
      ticks(4);
      rchk(`CLAM_OFS_CTRL_CAP, 32'h64);
      running <= 1'b1;
      ticks(4);
      rchk(`CLAM_OFS_CTRL_CAP, 32'h63);
      heat <= 2'h3;
      ticks(89);
      rchk(`CLAM_OFS_CTRL_CAP, 32'h0A);
      rchk(`CLAM_OFS_FLAGS, 32'h0);
      ticks(1);
      running <= 1'b0;
      rchk(`CLAM_OFS_CTRL_CAP, 32'h09);
      rchk(`CLAM_OFS_FLAGS, 32'h1);
      `CHK(alarm, 1'b1)
   endtask
   task automatic t_meas();
      int n;
      n = 0;
      apb(1'b1, `CLAM_OFS_MEASURE, 32'h2);
      rchk(`CLAM_OFS_MEASURE, 32'h0);
      apb(1'b1, `CLAM_OFS_MEASURE, 32'h1);
      apb(1'b1, `CLAM_OFS_MEASURE, 32'h0);
      rchk(`CLAM_OFS_MEASURE, 32'h0);
      apb(1'b1, `CLAM_OFS_MEASURE, 32'h1);
      rchk(`CLAM_OFS_MEASURE, 32'h1);
      mcap <= 7'h55;
      poff();
      repeat (30) begin
         @(posedge pclk);
         if (dc === 1'b1) n++;
      end
      `CHK(n, 8)
      rchk(`CLAM_OFS_MEASURE, 32'h3);
      rchk(`CLAM_OFS_MAIN_CAP, 32'h55);
      rchk(`CLAM_OFS_FLAGS, 32'h3);
   endtask
   task automatic t_abort();
      mcap <= 7'h10;
      apb(1'b1, `CLAM_OFS_MEASURE, 32'h1);
      cond.motor_present <= 1'b0;
      poff();
      cond.motor_present <= 1'b1;
      rchk(`CLAM_OFS_MEASURE, 32'h9);
      apb(1'b1, `CLAM_OFS_MEASURE, 32'h1);
      cond.output_shutoff_input <= 1'b1;
      poff();
      cond.output_shutoff_input <= 1'b0;
      rchk(`CLAM_OFS_MEASURE, 32'h1);
      poff();
      step(2);
      cond.power_restored <= 1'b1;
      step(1);
      cond.power_restored <= 1'b0;
      rchk(`CLAM_OFS_MEASURE, 32'h8);
      apb(1'b1, `CLAM_OFS_MEASURE, 32'h1);
      poff();
      step(2);
      cond.start_cmd <= 1'b1;
      step(1);
      cond.start_cmd <= 1'b0;
      rchk(`CLAM_OFS_MEASURE, 32'h8);
      apb(1'b1, `CLAM_OFS_MEASURE, 32'h1);
      poff();
      step(2);
      cond.motor_coasting <= 1'b1;
      step(1);
      cond.motor_coasting <= 1'b0;
      rchk(`CLAM_OFS_MEASURE, 32'h9);
      rchk(`CLAM_OFS_MAIN_CAP, 32'h55);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      step(3);
      presetn <= 1'b1;
      t_reset();
      t_inrush();
      t_fan();
      t_ctrl();
      t_meas();
      t_abort();
      give_verdict();
   end
endmodule
`default_nettype wire
